//--- inc/ctim_pkg.sv
// ctim_pkg: constants and state types of the four-channel capture/compare timer
// Contract
// - counter ticks at bus clock over selected divisor
// - direction bit zero capture, one compare
// - capture edge copies counter into channel register
// - capture sets flag; irq needs channel enable
// - counter match performs set, clear or toggle
// - compare match sets flag; irq needs enable
// - mode and level pick action; zero disconnects; code still drives a pin set in the channel-three mask
// - force bit acts immediately, flag untouched
// - channel three compare overrides other channels
// - mask selects pins driven from channel-three data
// - reset-on-match clears counter on channel three
// - port write only latches; shows on release
// - four active-high channel interrupt outputs, gated
// - overflow interrupt output gated by its enable
// - five interrupt sources: four channels, overflow
// - overflow flag write-one-clear, fast clear option
// - capture-mode register writes are ignored
`default_nettype none
package ctim_pkg;

  // register byte offsets on the APB slave
  localparam logic [7:0] CTIM_ADDR_CTRL = 8'h00;
  localparam logic [7:0] CTIM_ADDR_DIR = 8'h04;
  localparam logic [7:0] CTIM_ADDR_IEN = 8'h08;
  localparam logic [7:0] CTIM_ADDR_OUTCTL = 8'h0C;
  localparam logic [7:0] CTIM_ADDR_FORCE = 8'h10;
  localparam logic [7:0] CTIM_ADDR_MASK3 = 8'h14;
  localparam logic [7:0] CTIM_ADDR_DATA3 = 8'h18;
  localparam logic [7:0] CTIM_ADDR_FLAG1 = 8'h1C;
  localparam logic [7:0] CTIM_ADDR_FLAG2 = 8'h20;
  localparam logic [7:0] CTIM_ADDR_COUNT = 8'h24;
  localparam logic [7:0] CTIM_ADDR_EDGE = 8'h28;
  localparam logic [7:0] CTIM_ADDR_PORT = 8'h2C;
  localparam logic [7:0] CTIM_ADDR_CC0 = 8'h30;
  localparam logic [7:0] CTIM_ADDR_CC3 = 8'h3C;
  localparam logic [7:0] CTIM_ADDR_STRIDE = 8'h04;

  // field positions
  localparam int CTIM_CTRL_PRESCALE_LSB = 0;
  localparam int CTIM_CTRL_CRE_BIT = 3;
  localparam int CTIM_CTRL_FFC_BIT = 4;
  localparam int CTIM_CTRL_TOI_BIT = 5;
  localparam int CTIM_OUTCTL_LEVEL_LSB = 4;
  localparam int CTIM_PORT_DIR_LSB = 4;
  localparam int CTIM_FLAG2_TOF_BIT = 7;
  localparam int CTIM_EDGE_RISE_BIT = 0;
  localparam int CTIM_EDGE_FALL_BIT = 1;

  // values after reset, and the counter maximum
  localparam logic [15:0] CTIM_CNT_RESET = 16'h0000;
  localparam logic [15:0] CTIM_CNT_MAX = 16'hFFFF;
  localparam logic [3:0] CTIM_OE_N_RESET = 4'hF;
  localparam logic [6:0] CTIM_DIV_RESET = 7'h00;

  // compare action codes, {compare_output_mode, compare_output_level}
  localparam logic [1:0] CTIM_MODE_OFF = 2'h0;
  localparam logic [1:0] CTIM_MODE_TOGGLE = 2'h1;
  localparam logic [1:0] CTIM_MODE_CLEAR = 2'h2;
  localparam logic [1:0] CTIM_MODE_SET = 2'h3;

  typedef struct packed {
    logic [2:0] prescale_select_q;
    logic cre_q;
    logic ffc_q;
    logic toi_q;
    logic [3:0] dir_q;
    logic [3:0] ien_q;
    logic [3:0] om_q;
    logic [3:0] ol_q;
    logic [3:0] force_q;
    logic [3:0] mask3_q;
    logic [3:0] data3_q;
    logic [3:0] flag_q;
    logic tof_q;
    logic [7:0] edge_q;
    logic [3:0] port_q;
    logic [3:0] gpo_dir_q;
    logic [3:0] cmp_q;
    logic [3:0] pin_q;
    logic [3:0] oe_n_q;
    logic fresh_q;
    logic [15:0] cnt_q;
    logic [3:0][15:0] cc_q;
    logic [31:0] prdata_q;
    logic slverr_q;
  } ctim_state_t;

  typedef struct packed {
    logic [6:0] div_q;
    logic [2:0] sel_q;
  } ctim_presc_state_t;

  typedef struct packed {
    logic [3:0] s1_q;
    logic [3:0] s2_q;
    logic [3:0] prev_q;
  } ctim_sync_state_t;

endpackage
`default_nettype wire

//--- test/ctim_pin_model.sv
// ctim_pin_model: external sources and loads on the timer channel pins
`timescale 1ns/1ns
`default_nettype none
module ctim_pin_model (
  // clock
  input wire logic clk_sys,
  // pins as seen from outside
  input wire logic [3:0] pin_out,
  input wire logic [3:0] pin_oe_n,
  output logic [3:0] pin_in
);
  logic [3:0] src_q = 4'h0;
  // a driving timer wins the wire, otherwise the outside source sets it
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      pin_in[i] = pin_oe_n[i] ? src_q[i] : pin_out[i];
    end
  end
  // shorter pulses may be lost, so they are stretched to three clocks
  task pulse(input int ch, input int width);
    int w;
    w = (width < 3) ? 3 : width;
    @(posedge clk_sys);
    src_q[ch] <= 1'b1;
    repeat (w) @(posedge clk_sys);
    src_q[ch] <= 1'b0;
  endtask
endmodule // ctim_pin_model
`default_nettype wire

//--- test/tb_ctim_top.sv
// tb_ctim_top: self-checking bench for the capture/compare timer
`timescale 1ns/1ns
`default_nettype none
module tb_ctim_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [3:0] pin_in;
  logic [3:0] pin_out;
  logic [3:0] pin_oe_n;
  logic [3:0] ch_irq;
  logic ovf_irq;
  int miscompares = 0;
  int samples_checked = 0;
  int n;
  logic [31:0] rd;
  logic [15:0] cnt;
  logic err;
  logic p3;
  logic [7:0] octl [4] = '{8'h11, 8'h01, 8'h10, 8'h10};
  logic [3:0] opin = 4'b0101;

  always #20 clk_sys = ~clk_sys;

  ctim_top ctim_top_i (.clk_sys(clk_sys), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .ch_irq(ch_irq), .ovf_irq(ovf_irq));
  ctim_pin_model ctim_pin_model_i (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_in(pin_in));

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // answer is taken at the access edge that sees pready high, then released
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
    @(posedge clk_sys);
    paddr <= addr;
    pwrite <= wr;
    pwdata <= wdata;
    psel <= 1'b1;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    xfer(1'b0, addr, 32'h0);
    check(rd, exp);
  endtask

  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(negedge clk_sys);
    check({23'h0, ovf_irq, ch_irq, pin_oe_n}, 32'h0000000F);
    rd_chk(ctim_pkg::CTIM_ADDR_DIR, 32'h0);
    xfer(1'b0, 8'h41, 32'h0);
    check({err, rd[30:0]}, 32'h80000000);
    // spacing of 256 clocks between count snapshots
    for (int s = 0; s < 8; s++) begin
      xfer(1'b1, ctim_pkg::CTIM_ADDR_CTRL, 32'(s));
      xfer(1'b0, ctim_pkg::CTIM_ADDR_COUNT, 32'h0);
      cnt = rd[15:0];
      repeat (253) @(posedge clk_sys);
      xfer(1'b0, ctim_pkg::CTIM_ADDR_COUNT, 32'h0);
      check({16'h0, rd[15:0] - cnt}, 32'd256 >> s);
    end
    xfer(1'b1, ctim_pkg::CTIM_ADDR_IEN, 32'h5);
    // rising edges on channels 0 and 2, falling edges on 1 and 3
    xfer(1'b1, ctim_pkg::CTIM_ADDR_EDGE, 32'h99);
    for (int c = 0; c < 4; c++) begin
      // reselecting restarts the divider, so the count holds for 128 clocks
      xfer(1'b1, ctim_pkg::CTIM_ADDR_CTRL, 32'h6);
      xfer(1'b1, ctim_pkg::CTIM_ADDR_CTRL, 32'h7);
      xfer(1'b1, ctim_pkg::CTIM_ADDR_CC0 + 8'(4 * c), 32'h1234);
      xfer(1'b0, ctim_pkg::CTIM_ADDR_COUNT, 32'h0);
      cnt = rd[15:0];
      ctim_pin_model_i.pulse(c, 2);
      repeat (6) @(posedge clk_sys);
      @(negedge clk_sys);
      check({28'h0, ch_irq}, 32'(4'h5 & (4'h1 << c)));
      rd_chk(ctim_pkg::CTIM_ADDR_CC0 + 8'(4 * c), {16'h0, cnt});
      rd_chk(ctim_pkg::CTIM_ADDR_FLAG1, 32'(4'h1 << c));
      xfer(1'b1, ctim_pkg::CTIM_ADDR_FLAG1, 32'(4'h1 << c));
    end
    xfer(1'b1, ctim_pkg::CTIM_ADDR_DIR, 32'hB);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, ctim_pkg::CTIM_ADDR_OUTCTL, {24'h0, octl[k]});
      xfer(1'b1, ctim_pkg::CTIM_ADDR_FORCE, 32'h1);
      @(posedge clk_sys);
      @(negedge clk_sys);
      check({30'h0, pin_oe_n[0], pin_out[0]}, {31'h0, opin[k]});
    end
    xfer(1'b1, ctim_pkg::CTIM_ADDR_OUTCTL, 32'h0);
    @(negedge clk_sys);
    check({31'h0, pin_oe_n[0]}, 32'h1);
    rd_chk(ctim_pkg::CTIM_ADDR_FLAG1, 32'h0);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_MASK3, 32'h3);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_DATA3, 32'h1);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_OUTCTL, 32'h01);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_FORCE, 32'h9);
    @(posedge clk_sys);
    @(negedge clk_sys);
    check({28'h0, pin_oe_n[1:0], pin_out[1:0]}, 32'h1);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_PORT, 32'h10);
    @(negedge clk_sys);
    check({31'h0, pin_out[0]}, 32'h1);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_MASK3, 32'h0);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_DIR, 32'h8);
    @(negedge clk_sys);
    check({30'h0, pin_oe_n[0], pin_out[0]}, 32'h0);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_PORT, 32'h0);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_DIR, 32'h9);
    xfer(1'b0, ctim_pkg::CTIM_ADDR_COUNT, 32'h0);
    cnt = rd[15:0];
    xfer(1'b1, ctim_pkg::CTIM_ADDR_CC3, {16'h0, cnt + 16'h0100});
    xfer(1'b1, ctim_pkg::CTIM_ADDR_CC0, {16'h0, cnt + 16'h0040});
    xfer(1'b1, ctim_pkg::CTIM_ADDR_OUTCTL, 32'h91);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_IEN, 32'h8);
    @(negedge clk_sys);
    p3 = pin_out[3];
    xfer(1'b1, ctim_pkg::CTIM_ADDR_CTRL, 32'h08);
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while (ch_irq[3] !== 1'b1 && n < 600);
    check({26'h0, pin_out[3], pin_out[0], ch_irq}, {26'h0, ~p3, 5'h18});
    rd_chk(ctim_pkg::CTIM_ADDR_FLAG1, 32'h9);
    xfer(1'b0, ctim_pkg::CTIM_ADDR_COUNT, 32'h0);
    check(32'(rd[15:0] <= cnt + 16'h0100), 32'h1);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_CTRL, 32'h0);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_FLAG2, 32'h80);
    n = 0;
    do begin
      xfer(1'b0, ctim_pkg::CTIM_ADDR_FLAG2, 32'h0);
      n++;
    end while (rd[7] !== 1'b1 && n < 23000);
    check(rd, 32'h80);
    check({31'h0, ovf_irq}, 32'h0);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_CTRL, 32'h20);
    xfer(1'b0, ctim_pkg::CTIM_ADDR_COUNT, 32'h0);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_FLAG2, 32'h0);
    @(negedge clk_sys);
    check({31'h0, ovf_irq}, 32'h1);
    xfer(1'b1, ctim_pkg::CTIM_ADDR_CTRL, 32'h30);
    xfer(1'b0, ctim_pkg::CTIM_ADDR_COUNT, 32'h0);
    @(negedge clk_sys);
    check({31'h0, ovf_irq}, 32'h0);
    final_report();
  end

  // guards against a hang in any unbounded wait above
  initial begin
    repeat (95000) @(posedge clk_sys);
    miscompares++;
    final_report();
  end
endmodule // tb_ctim_top
`default_nettype wire

//--- verilog/ctim_edge_sync.sv
// ctim_edge_sync: synchronises capture pins and detects selected edges
`timescale 1ns/1ns
`default_nettype none
module ctim_edge_sync (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // pins and edge selection, two bits per channel
  input wire logic [3:0] pin_in,
  input wire logic [7:0] edge_sel,
  output logic [3:0] edge_hit
);
  ctim_pkg::ctim_sync_state_t st_q, st_d;

  always_comb begin
    st_d.s1_q = pin_in;
    st_d.s2_q = st_q.s1_q;
    st_d.prev_q = st_q.s2_q;
    for (int i = 0; i < 4; i++) begin
      edge_hit[i] = (edge_sel[2*i+ctim_pkg::CTIM_EDGE_RISE_BIT] && st_q.s2_q[i] && !st_q.prev_q[i])
        || (edge_sel[2*i+ctim_pkg::CTIM_EDGE_FALL_BIT] && !st_q.s2_q[i] && st_q.prev_q[i]);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  sync_rise_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!pin_in[0] ##1 pin_in[0]) |-> ##2 (edge_hit[0] || !edge_sel[0]))
    else $error("rising edge not seen two cycles after the pin");

endmodule // ctim_edge_sync
`default_nettype wire

//--- verilog/ctim_prescaler.sv
// ctim_prescaler: divides the bus clock into counter ticks
`timescale 1ns/1ns
`default_nettype none
module ctim_prescaler (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // divisor select and tick
  input wire logic [2:0] sel,
  output logic tick
);
  ctim_pkg::ctim_presc_state_t st_q, st_d;
  logic [6:0] mask;

  always_comb begin
    mask = 7'((8'h01 << sel) - 8'h01);
    tick = ((st_q.div_q & mask) == mask);
    st_d = st_q;
    st_d.sel_q = sel;
    // restart on a new divisor so the first period is whole
    if (sel != st_q.sel_q) begin
      st_d.div_q = ctim_pkg::CTIM_DIV_RESET;
    end else begin
      st_d.div_q = st_q.div_q + 7'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  div_four_a: assert property (
    @(posedge clk_sys) disable iff (rst || sel != st_q.sel_q)
    (tick && sel == 3'h2) |=> (!tick) [*3] ##1 tick)
    else $error("divide by four tick spacing wrong");

endmodule // ctim_prescaler
`default_nettype wire

//--- verilog/ctim_top.sv
// ctim_top: four-channel capture/compare timer with APB registers
`timescale 1ns/1ns
`default_nettype none
module ctim_top (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // channel pins
  input wire logic [3:0] pin_in,
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe_n,
  // interrupt requests
  output logic [3:0] ch_irq,
  output logic ovf_irq
);
  ctim_pkg::ctim_state_t st_q, st_d;

  logic tick;
  logic [3:0] edge_hit;
  logic acc;
  logic wr;
  logic [3:0] match;
  logic [3:0] cap_ev;
  logic [3:0] act;
  logic [3:0] clr1;
  logic [3:0] owned;
  logic ovr3;
  logic reset3;
  logic [31:0] rd;
  logic [31:0] wm;

  function automatic logic [7:0] ctim_cc_addr(input int idx);
    return ctim_pkg::CTIM_ADDR_CC0 + 8'(idx) * ctim_pkg::CTIM_ADDR_STRIDE;
  endfunction

  function automatic logic ctim_mapped(input logic [7:0] a);
    logic ok;
    ok = (a[1:0] == 2'h0) && (a <= ctim_cc_addr(3));
    return ok;
  endfunction

  // byte-lane merge of write data onto the old register value
  function automatic logic [31:0] ctim_wmerge(input logic [31:0] old, input logic [31:0] wd,
                                              input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic ctim_action(input logic cur, input logic [1:0] mode);
    logic r;
    case (mode)
      ctim_pkg::CTIM_MODE_TOGGLE: r = ~cur;
      ctim_pkg::CTIM_MODE_CLEAR: r = 1'b0;
      ctim_pkg::CTIM_MODE_SET: r = 1'b1;
      default: r = cur;
    endcase
    return r;
  endfunction

  ctim_prescaler u_presc (
    .clk_sys(clk_sys),
    .rst(rst),
    .sel(st_q.prescale_select_q),
    .tick(tick)
  );

  ctim_edge_sync u_sync (
    .clk_sys(clk_sys),
    .rst(rst),
    .pin_in(pin_in),
    .edge_sel(st_q.edge_q),
    .edge_hit(edge_hit)
  );

  // read view of the register file
  always_comb begin
    rd = 32'h0000_0000;
    case (paddr)
      ctim_pkg::CTIM_ADDR_CTRL: begin
        rd[ctim_pkg::CTIM_CTRL_PRESCALE_LSB +: 3] = st_q.prescale_select_q;
        rd[ctim_pkg::CTIM_CTRL_CRE_BIT] = st_q.cre_q;
        rd[ctim_pkg::CTIM_CTRL_FFC_BIT] = st_q.ffc_q;
        rd[ctim_pkg::CTIM_CTRL_TOI_BIT] = st_q.toi_q;
      end
      ctim_pkg::CTIM_ADDR_DIR: rd[3:0] = st_q.dir_q;
      ctim_pkg::CTIM_ADDR_IEN: rd[3:0] = st_q.ien_q;
      ctim_pkg::CTIM_ADDR_OUTCTL: begin
        rd[3:0] = st_q.om_q;
        rd[ctim_pkg::CTIM_OUTCTL_LEVEL_LSB +: 4] = st_q.ol_q;
      end
      ctim_pkg::CTIM_ADDR_MASK3: rd[3:0] = st_q.mask3_q;
      ctim_pkg::CTIM_ADDR_DATA3: rd[3:0] = st_q.data3_q;
      ctim_pkg::CTIM_ADDR_FLAG1: rd[3:0] = st_q.flag_q;
      ctim_pkg::CTIM_ADDR_FLAG2: rd[ctim_pkg::CTIM_FLAG2_TOF_BIT] = st_q.tof_q;
      ctim_pkg::CTIM_ADDR_COUNT: rd[15:0] = st_q.cnt_q;
      ctim_pkg::CTIM_ADDR_EDGE: rd[7:0] = st_q.edge_q;
      ctim_pkg::CTIM_ADDR_PORT: begin
        rd[3:0] = st_q.port_q;
        rd[ctim_pkg::CTIM_PORT_DIR_LSB +: 4] = st_q.gpo_dir_q;
      end
      default: begin
        for (int i = 0; i < 4; i++) begin
          if (paddr == ctim_cc_addr(i)) begin
            rd[15:0] = st_q.cc_q[i];
          end
        end
      end
    endcase
  end

  always_comb begin
    acc = psel && penable;
    wr = acc && pwrite;
    st_d = st_q;
    wm = 32'h0000_0000;
    clr1 = 4'h0;

    // register read data is frozen at setup so it comes from a flop
    if (psel && !penable) begin
      st_d.prdata_q = rd;
      st_d.slverr_q = !ctim_mapped(paddr);
    end

    // compares are judged only once per new counter value
    for (int i = 0; i < 4; i++) begin
      match[i] = st_q.fresh_q && st_q.dir_q[i] && (st_q.cnt_q == st_q.cc_q[i]);
      cap_ev[i] = !st_q.dir_q[i] && edge_hit[i];
      act[i] = st_q.dir_q[i] && (match[i] || st_q.force_q[i]);
    end
    ovr3 = act[3];
    reset3 = match[3] && st_q.cre_q;

    // free-running counter
    st_d.fresh_q = tick || reset3;
    if (reset3) begin
      st_d.cnt_q = ctim_pkg::CTIM_CNT_RESET;
    end else if (tick) begin
      st_d.cnt_q = st_q.cnt_q + 16'h0001;
    end

    // register writes
    st_d.force_q = 4'h0;
    if (wr) begin
      case (paddr)
        ctim_pkg::CTIM_ADDR_CTRL: begin
          wm = ctim_wmerge({26'h0, st_q.toi_q, st_q.ffc_q, st_q.cre_q, st_q.prescale_select_q}, pwdata, pstrb);
          st_d.prescale_select_q = wm[ctim_pkg::CTIM_CTRL_PRESCALE_LSB +: 3];
          st_d.cre_q = wm[ctim_pkg::CTIM_CTRL_CRE_BIT];
          st_d.ffc_q = wm[ctim_pkg::CTIM_CTRL_FFC_BIT];
          st_d.toi_q = wm[ctim_pkg::CTIM_CTRL_TOI_BIT];
        end
        ctim_pkg::CTIM_ADDR_DIR: begin
          wm = ctim_wmerge({28'h0, st_q.dir_q}, pwdata, pstrb);
          st_d.dir_q = wm[3:0];
        end
        ctim_pkg::CTIM_ADDR_IEN: begin
          wm = ctim_wmerge({28'h0, st_q.ien_q}, pwdata, pstrb);
          st_d.ien_q = wm[3:0];
        end
        ctim_pkg::CTIM_ADDR_OUTCTL: begin
          wm = ctim_wmerge({24'h0, st_q.ol_q, st_q.om_q}, pwdata, pstrb);
          st_d.om_q = wm[3:0];
          st_d.ol_q = wm[ctim_pkg::CTIM_OUTCTL_LEVEL_LSB +: 4];
        end
        ctim_pkg::CTIM_ADDR_FORCE: begin
          wm = ctim_wmerge(32'h0000_0000, pwdata, pstrb);
          st_d.force_q = wm[3:0];
        end
        ctim_pkg::CTIM_ADDR_MASK3: begin
          wm = ctim_wmerge({28'h0, st_q.mask3_q}, pwdata, pstrb);
          st_d.mask3_q = wm[3:0];
        end
        ctim_pkg::CTIM_ADDR_DATA3: begin
          wm = ctim_wmerge({28'h0, st_q.data3_q}, pwdata, pstrb);
          st_d.data3_q = wm[3:0];
        end
        ctim_pkg::CTIM_ADDR_FLAG1: begin
          wm = ctim_wmerge(32'h0000_0000, pwdata, pstrb);
          clr1 = wm[3:0];
        end
        ctim_pkg::CTIM_ADDR_EDGE: begin
          wm = ctim_wmerge({24'h0, st_q.edge_q}, pwdata, pstrb);
          st_d.edge_q = wm[7:0];
        end
        ctim_pkg::CTIM_ADDR_PORT: begin
          wm = ctim_wmerge({24'h0, st_q.gpo_dir_q, st_q.port_q}, pwdata, pstrb);
          st_d.port_q = wm[3:0];
          st_d.gpo_dir_q = wm[ctim_pkg::CTIM_PORT_DIR_LSB +: 4];
        end
        default: begin
          for (int i = 0; i < 4; i++) begin
            // a channel in capture mode keeps its captured value
            if (paddr == ctim_cc_addr(i) && st_q.dir_q[i]) begin
              wm = ctim_wmerge({16'h0, st_q.cc_q[i]}, pwdata, pstrb);
              st_d.cc_q[i] = wm[15:0];
            end
          end
        end
      endcase
    end

    // capture after register writes, so a capture is never lost
    for (int i = 0; i < 4; i++) begin
      if (cap_ev[i]) begin
        st_d.cc_q[i] = st_q.cnt_q;
      end
    end

    // channel flags: hardware set wins over write-one-clear
    st_d.flag_q = (st_q.flag_q & ~clr1) | cap_ev | match;

    // overflow flag
    if (wr && paddr == ctim_pkg::CTIM_ADDR_FLAG2 && pstrb[0] && pwdata[ctim_pkg::CTIM_FLAG2_TOF_BIT]) begin
      st_d.tof_q = 1'b0;
    end
    if (acc && st_q.ffc_q && paddr == ctim_pkg::CTIM_ADDR_COUNT) begin
      st_d.tof_q = 1'b0;
    end
    if (tick && !reset3 && st_q.cnt_q == ctim_pkg::CTIM_CNT_MAX) begin
      st_d.tof_q = 1'b1;
    end

    // compare outputs; channel three data overrides masked channels
    for (int i = 0; i < 4; i++) begin
      if (act[i]) begin
        st_d.cmp_q[i] = ctim_action(st_q.cmp_q[i], {st_q.om_q[i], st_q.ol_q[i]});
      end
      if (ovr3 && st_q.mask3_q[i] && st_q.dir_q[i]) begin
        st_d.cmp_q[i] = st_q.data3_q[i];
      end
    end

    // pin ownership follows the next configuration
    for (int i = 0; i < 4; i++) begin
      owned[i] = st_d.dir_q[i] && (({st_d.om_q[i], st_d.ol_q[i]} != ctim_pkg::CTIM_MODE_OFF)
                 || st_d.mask3_q[i]);
      st_d.pin_q[i] = owned[i] ? st_d.cmp_q[i] : st_d.port_q[i];
      st_d.oe_n_q[i] = !(owned[i] || st_d.gpo_dir_q[i]);
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q <= '0;
      st_q.oe_n_q <= ctim_pkg::CTIM_OE_N_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // zero-wait slave: the answer stands in the first access cycle
  assign pready = 1'b1;
  assign prdata = st_q.prdata_q;
  assign pslverr = acc && st_q.slverr_q;
  assign pin_out = st_q.pin_q;
  assign pin_oe_n = st_q.oe_n_q;
  assign ch_irq = st_q.flag_q & st_q.ien_q;
  assign ovf_irq = st_q.tof_q && st_q.toi_q;

  cap_value_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    cap_ev[0] |=> st_q.cc_q[0] == $past(st_q.cnt_q))
    else $error("capture did not latch the counter");

  cap_flag_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (cap_ev[2] && st_q.ien_q[2]) |=> (st_q.flag_q[2] && ch_irq[2]))
    else $error("capture flag or irq missing");

  match_set_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (match[0] && {st_q.om_q[0], st_q.ol_q[0]} == ctim_pkg::CTIM_MODE_SET && !(ovr3 && st_q.mask3_q[0]))
    |=> st_q.cmp_q[0] ##1 pin_out[0])
    else $error("set on compare not applied");

  match_flag_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (match[0] && !st_q.ien_q[0]) |=> (st_q.flag_q[0] && !ch_irq[0]))
    else $error("compare flag or irq gating wrong");

  force_noflag_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (st_q.force_q[0] && !match[0] && !cap_ev[0] && !st_q.flag_q[0]) |=> !st_q.flag_q[0])
    else $error("forced compare set the flag");

  mask_override_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (ovr3 && st_q.mask3_q[1] && st_q.dir_q[1]) |=> st_q.cmp_q[1] == $past(st_q.data3_q[1]))
    else $error("channel three data not applied to masked channel");

  cnt_reset_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    reset3 |=> (st_q.cnt_q == ctim_pkg::CTIM_CNT_RESET && st_q.fresh_q))
    else $error("counter not reset on channel three match");

  gpo_latch_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (!st_q.dir_q[0] && st_q.gpo_dir_q[0]) |-> (pin_out[0] == st_q.port_q[0] && !pin_oe_n[0]))
    else $error("port latch not on released pin");

  wrap_ovf_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (tick && !reset3 && st_q.cnt_q == ctim_pkg::CTIM_CNT_MAX)
    |=> (st_q.cnt_q == ctim_pkg::CTIM_CNT_RESET && st_q.tof_q && ovf_irq == st_q.toi_q))
    else $error("wrap did not raise overflow");

  fast_clear_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (acc && st_q.ffc_q && paddr == ctim_pkg::CTIM_ADDR_COUNT && !(tick && st_q.cnt_q == ctim_pkg::CTIM_CNT_MAX))
    |=> !st_q.tof_q)
    else $error("counter access did not clear overflow");

  cc_ignore_a: assert property (
    @(posedge clk_sys) disable iff (rst)
    (wr && paddr == ctim_pkg::CTIM_ADDR_CC0 && !st_q.dir_q[0] && !cap_ev[0])
    |=> st_q.cc_q[0] == $past(st_q.cc_q[0]))
    else $error("capture register written in capture mode");

endmodule // ctim_top
`default_nettype wire
